// >>> design/esic_defines.vh
// Purpose: constants for the eight source interrupt controller
// Assumes: byte wide register port, 125 MHz system clock
// Notes:   register offsets are local indices on the register port
`ifndef ESIC_DEFINES_VH
`define ESIC_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ESIC_ADDR_W        4
`define ESIC_OFF_IRQ_EN    4'h0
`define ESIC_OFF_PRIO_LO   4'h1
`define ESIC_OFF_PRIO_HI   4'h2
`define ESIC_OFF_EXT23     4'h3
`define ESIC_OFF_TIMER_CONTROL_REG      4'h4
`define ESIC_OFF_FLAGS     4'h5
`define ESIC_OFF_STATUS    4'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ESIC_IE_GLOBAL     7
`define ESIC_IE_MASK       8'hbf
`define ESIC_PL_MASK       8'h3f
`define ESIC_X23_FLAG2     1
`define ESIC_X23_FLAG3     5
`define ESIC_X23_TYPE2     0
`define ESIC_X23_TYPE3     4
`define ESIC_X23_EN2       2
`define ESIC_X23_EN3       6
`define ESIC_X23_PL2       3
`define ESIC_X23_PL3       7
`define ESIC_TC_TYPE0      0
`define ESIC_TC_FLAG0      1
`define ESIC_TC_TYPE1      2
`define ESIC_TC_FLAG1      3
`define ESIC_TC_T0OVF      5
`define ESIC_TC_T1OVF      7
`define ESIC_FL_RX         0
`define ESIC_FL_TX         1
`define ESIC_FL_T2OVF      2
`define ESIC_FL_T2EXT      3

// ----------------------------------------------------------------
// Source indices in polling order and reset values
// ----------------------------------------------------------------
`define ESIC_SRC_EXT0      3'h0
`define ESIC_SRC_T0        3'h1
`define ESIC_SRC_EXT1      3'h2
`define ESIC_SRC_T1        3'h3
`define ESIC_SRC_UART      3'h4
`define ESIC_SRC_T2        3'h5
`define ESIC_SRC_EXT2      3'h6
`define ESIC_SRC_EXT3      3'h7
`define ESIC_RST_BYTE      8'h00
`define ESIC_VEC_BASE      8'h03
`define ESIC_LVL_NONE      3'h4

`endif

// >>> design/esic_ext_detect.v
// Purpose: synchronise one external request pin and find falling edges
// Assumes: pin is asynchronous to sys_clk
// Notes:   edge pulse is one cycle, level output is active high request
`timescale 1ns/1ps
`default_nettype none

module esic_ext_detect (
  input  wire sys_clk,
  input  wire nrst,
  input  wire pin_n,
  output wire low_level,
  output wire fall_pulse
);

  reg sync1_q;
  reg sync2_q;
  reg prev_q;

  // ----------------------------------------------------------------
  // Two stage synchroniser, then a history bit for edge detection
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= pin_n;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Only the second stage and its history are read
  assign low_level  = ~sync2_q;
  assign fall_pulse = prev_q & ~sync2_q;

endmodule // esic_ext_detect

`default_nettype wire

// >>> design/esic_arbiter.v
// Purpose: pick the winning source by level, then by polling order
// Assumes: requests already gated by enables
// Notes:   purely combinational, level 0 is the highest
`timescale 1ns/1ps
`default_nettype none
`include "esic_defines.vh"

module esic_arbiter (
  input  wire [7:0] req,
  input  wire [7:0] prio_hi,
  input  wire [7:0] prio_lo,
  output reg        win_valid,
  output reg  [2:0] win_src,
  output reg  [2:0] win_lvl
);

  integer i;
  reg [2:0] lvl;

  // Level 0 for pattern 11 down to level 3 for pattern 00
  function [2:0] esic_level;
    input hi;
    input lo;
    begin
      esic_level = {1'b0, ~hi, ~lo};
    end
  endfunction

  // ----------------------------------------------------------------
  // Scan from the last polled source so the first one wins ties
  // ----------------------------------------------------------------
  always @* begin
    win_valid = 1'b0;
    win_src   = `ESIC_SRC_EXT0;
    win_lvl   = `ESIC_LVL_NONE;
    lvl       = `ESIC_LVL_NONE;
    for (i = 7; i >= 0; i = i - 1) begin
      lvl = esic_level(prio_hi[i], prio_lo[i]);
      if (req[i] && (lvl <= win_lvl)) begin
        win_valid = 1'b1;
        win_src   = i[2:0];
        win_lvl   = lvl;
      end
    end
  end

endmodule // esic_arbiter

`default_nettype wire

// >>> design/esic_ctrl.v
// Purpose: eight source, four level interrupt controller for a CPU core
// Assumes: one 125 MHz clock, synchronous active low reset
// Notes:   request re-evaluated each cycle until the core acknowledges; return pops a level
`timescale 1ns/1ps
`default_nettype none
`include "esic_defines.vh"

// Overview of operation
// - Eight sources, each gated by own enable
// - Global enable clear blocks every interrupt
// - Enable register bit layout, bit 6 unused
// - High and low bit form four levels
// - Lower level never preempts running routine
// - Higher level wins simultaneous requests
// - Fixed polling order breaks equal-level ties
// - Vector addresses 03H to 3BH step eight
// - Each external input level or falling edge
// - External 2/3 type bit selects edge
// - Edge on external 2/3 sets flag
// - Vectoring clears edge external pending flag
// - Timer0/1 overflow flags cleared on vectoring
// - Serial request is rx OR tx, kept
// - Timer2 request is overflow OR external, kept
// - Software flag writes act like hardware, except external flags in level mode
// - Priority-low register bit layout, 7:6 unused
// - Priority-high register holds all eight
// - External 2/3 control register bit layout
module esic_ctrl (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       ext_irq0_pin,
  input  wire       ext_irq1_pin,
  input  wire       ext_irq2_pin,
  input  wire       ext_irq3_pin,
  input  wire       timer0_rollover,
  input  wire       timer1_rollover,
  input  wire       timer2_overflow_set,
  input  wire       timer2_external_set,
  input  wire       uart_rx_done_set,
  input  wire       uart_tx_done_set,
  input  wire       cpu_ack,
  input  wire       cpu_reti,
  output reg        irq_req_q,
  output reg  [7:0] irq_vector_q
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [7:0] irq_enable_q;
  reg  [7:0] prio_low_q;
  reg  [7:0] prio_high_q;
  reg  [7:0] ext23_ctrl_q;
  reg  [7:0] timer_control_reg_q;
  reg  [3:0] flags_q;
  reg  [3:0] active_q;        // one bit per level in service, bit 0 highest
  reg  [2:0] irq_src_q;
  reg  [2:0] irq_lvl_q;

  wire [3:0] ext_low;
  wire [3:0] ext_fall;
  wire [7:0] req_raw;
  wire [7:0] req_en;
  wire [7:0] prio_lo_all;
  wire       win_valid;
  wire [2:0] win_src;
  wire [2:0] win_lvl;
  wire       wr_timer_control_reg;
  wire       wr_x23;
  wire       wr_flags;
  wire       vec_take;
  wire [2:0] cur_lvl;
  wire [3:0] reti_pop;

  // Index of the highest active level, or none
  function [2:0] esic_top_level;
    input [3:0] act;
    begin
      if (act[0])
        esic_top_level = 3'h0;
      else if (act[1])
        esic_top_level = 3'h1;
      else if (act[2])
        esic_top_level = 3'h2;
      else if (act[3])
        esic_top_level = 3'h3;
      else
        esic_top_level = `ESIC_LVL_NONE;
    end
  endfunction

  // One-hot of a level index, for push and pop
  function [3:0] esic_level_bit;
    input [2:0] lvl;
    begin
      case (lvl)
        3'h0:    esic_level_bit = 4'h1;
        3'h1:    esic_level_bit = 4'h2;
        3'h2:    esic_level_bit = 4'h4;
        3'h3:    esic_level_bit = 4'h8;
        default: esic_level_bit = 4'h0;
      endcase
    end
  endfunction

  // Next state of a hardware set, software write, vector clear flag
  // Hardware set beats both clears so no event is lost
  function esic_flag_next;
    input cur;
    input hw_set;
    input sw_wr;
    input sw_val;
    input vec_clr;
    begin
      if (hw_set)
        esic_flag_next = 1'b1;
      else if (sw_wr)
        esic_flag_next = sw_val;
      else if (vec_clr)
        esic_flag_next = 1'b0;
      else
        esic_flag_next = cur;
    end
  endfunction

  // ----------------------------------------------------------------
  // External pin front ends
  // ----------------------------------------------------------------
  esic_ext_detect u_ext0 (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .pin_n      (ext_irq0_pin),
    .low_level  (ext_low[0]),
    .fall_pulse (ext_fall[0])
  );

  esic_ext_detect u_ext1 (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .pin_n      (ext_irq1_pin),
    .low_level  (ext_low[1]),
    .fall_pulse (ext_fall[1])
  );

  esic_ext_detect u_ext2 (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .pin_n      (ext_irq2_pin),
    .low_level  (ext_low[2]),
    .fall_pulse (ext_fall[2])
  );

  esic_ext_detect u_ext3 (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .pin_n      (ext_irq3_pin),
    .low_level  (ext_low[3]),
    .fall_pulse (ext_fall[3])
  );

  // ----------------------------------------------------------------
  // Write decode and vectoring event
  // ----------------------------------------------------------------
  assign wr_timer_control_reg  = reg_wr && (reg_addr == `ESIC_OFF_TIMER_CONTROL_REG);
  assign wr_x23   = reg_wr && (reg_addr == `ESIC_OFF_EXT23);
  assign wr_flags = reg_wr && (reg_addr == `ESIC_OFF_FLAGS);
  assign vec_take = irq_req_q && cpu_ack;

  // ----------------------------------------------------------------
  // Request vector in polling order
  // ----------------------------------------------------------------
  // A level-triggered source follows the pin directly; the outside
  // requester must release it before returning, or it re-enters.
  assign req_raw[`ESIC_SRC_EXT0] = timer_control_reg_q[`ESIC_TC_FLAG0];
  assign req_raw[`ESIC_SRC_T0]   = timer_control_reg_q[`ESIC_TC_T0OVF];
  assign req_raw[`ESIC_SRC_EXT1] = timer_control_reg_q[`ESIC_TC_FLAG1];
  assign req_raw[`ESIC_SRC_T1]   = timer_control_reg_q[`ESIC_TC_T1OVF];
  assign req_raw[`ESIC_SRC_UART] = flags_q[`ESIC_FL_RX] | flags_q[`ESIC_FL_TX];
  assign req_raw[`ESIC_SRC_T2]   = flags_q[`ESIC_FL_T2OVF] | flags_q[`ESIC_FL_T2EXT];
  assign req_raw[`ESIC_SRC_EXT2] = ext23_ctrl_q[`ESIC_X23_FLAG2];
  assign req_raw[`ESIC_SRC_EXT3] = ext23_ctrl_q[`ESIC_X23_FLAG3];

  // Individual enables, then the global gate
  assign req_en = {ext23_ctrl_q[`ESIC_X23_EN3], ext23_ctrl_q[`ESIC_X23_EN2],
                   irq_enable_q[5:0]} & req_raw
                  & {8{irq_enable_q[`ESIC_IE_GLOBAL]}};

  // Low priority bits of ext2/3 live in the external control register
  assign prio_lo_all = {ext23_ctrl_q[`ESIC_X23_PL3], ext23_ctrl_q[`ESIC_X23_PL2],
                        prio_low_q[5:0]};

  esic_arbiter u_arb (
    .req       (req_en),
    .prio_hi   (prio_high_q),
    .prio_lo   (prio_lo_all),
    .win_valid (win_valid),
    .win_src   (win_src),
    .win_lvl   (win_lvl)
  );

  assign cur_lvl  = esic_top_level(active_q);
  assign reti_pop = esic_level_bit(cur_lvl);

  // ----------------------------------------------------------------
  // Register file and flag updates
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      irq_enable_q <= `ESIC_RST_BYTE;
      prio_low_q   <= `ESIC_RST_BYTE;
      prio_high_q  <= `ESIC_RST_BYTE;
      ext23_ctrl_q <= `ESIC_RST_BYTE;
      timer_control_reg_q       <= `ESIC_RST_BYTE;
      flags_q      <= 4'h0;
    end else begin
      if (reg_wr && (reg_addr == `ESIC_OFF_IRQ_EN))
        irq_enable_q <= reg_wdata & `ESIC_IE_MASK;
      if (reg_wr && (reg_addr == `ESIC_OFF_PRIO_LO))
        prio_low_q <= reg_wdata & `ESIC_PL_MASK;
      if (reg_wr && (reg_addr == `ESIC_OFF_PRIO_HI))
        prio_high_q <= reg_wdata;
      // Control fields of the external 2/3 register
      if (wr_x23) begin
        ext23_ctrl_q[`ESIC_X23_PL3]   <= reg_wdata[`ESIC_X23_PL3];
        ext23_ctrl_q[`ESIC_X23_EN3]   <= reg_wdata[`ESIC_X23_EN3];
        ext23_ctrl_q[`ESIC_X23_TYPE3] <= reg_wdata[`ESIC_X23_TYPE3];
        ext23_ctrl_q[`ESIC_X23_PL2]   <= reg_wdata[`ESIC_X23_PL2];
        ext23_ctrl_q[`ESIC_X23_EN2]   <= reg_wdata[`ESIC_X23_EN2];
        ext23_ctrl_q[`ESIC_X23_TYPE2] <= reg_wdata[`ESIC_X23_TYPE2];
      end
      // External 2/3 pending: edge mode latches, level mode follows pin
      if (ext23_ctrl_q[`ESIC_X23_TYPE2])
        ext23_ctrl_q[`ESIC_X23_FLAG2] <= esic_flag_next(
          ext23_ctrl_q[`ESIC_X23_FLAG2], ext_fall[2], wr_x23,
          reg_wdata[`ESIC_X23_FLAG2],
          vec_take && (irq_src_q == `ESIC_SRC_EXT2));
      else
        ext23_ctrl_q[`ESIC_X23_FLAG2] <= ext_low[2];
      if (ext23_ctrl_q[`ESIC_X23_TYPE3])
        ext23_ctrl_q[`ESIC_X23_FLAG3] <= esic_flag_next(
          ext23_ctrl_q[`ESIC_X23_FLAG3], ext_fall[3], wr_x23,
          reg_wdata[`ESIC_X23_FLAG3],
          vec_take && (irq_src_q == `ESIC_SRC_EXT3));
      else
        ext23_ctrl_q[`ESIC_X23_FLAG3] <= ext_low[3];
      // Timer control: trigger types, ext0/1 flags, timer overflow flags
      if (wr_timer_control_reg) begin
        timer_control_reg_q[`ESIC_TC_TYPE0] <= reg_wdata[`ESIC_TC_TYPE0];
        timer_control_reg_q[`ESIC_TC_TYPE1] <= reg_wdata[`ESIC_TC_TYPE1];
      end
      if (timer_control_reg_q[`ESIC_TC_TYPE0])
        timer_control_reg_q[`ESIC_TC_FLAG0] <= esic_flag_next(timer_control_reg_q[`ESIC_TC_FLAG0], ext_fall[0],
          wr_timer_control_reg, reg_wdata[`ESIC_TC_FLAG0],
          vec_take && (irq_src_q == `ESIC_SRC_EXT0));
      else
        timer_control_reg_q[`ESIC_TC_FLAG0] <= ext_low[0];
      if (timer_control_reg_q[`ESIC_TC_TYPE1])
        timer_control_reg_q[`ESIC_TC_FLAG1] <= esic_flag_next(timer_control_reg_q[`ESIC_TC_FLAG1], ext_fall[1],
          wr_timer_control_reg, reg_wdata[`ESIC_TC_FLAG1],
          vec_take && (irq_src_q == `ESIC_SRC_EXT1));
      else
        timer_control_reg_q[`ESIC_TC_FLAG1] <= ext_low[1];
      timer_control_reg_q[`ESIC_TC_T0OVF] <= esic_flag_next(timer_control_reg_q[`ESIC_TC_T0OVF], timer0_rollover,
        wr_timer_control_reg, reg_wdata[`ESIC_TC_T0OVF],
        vec_take && (irq_src_q == `ESIC_SRC_T0));
      timer_control_reg_q[`ESIC_TC_T1OVF] <= esic_flag_next(timer_control_reg_q[`ESIC_TC_T1OVF], timer1_rollover,
        wr_timer_control_reg, reg_wdata[`ESIC_TC_T1OVF],
        vec_take && (irq_src_q == `ESIC_SRC_T1));
      // Serial and timer2 flags are never cleared by vectoring
      flags_q[`ESIC_FL_RX] <= esic_flag_next(flags_q[`ESIC_FL_RX], uart_rx_done_set,
        wr_flags, reg_wdata[`ESIC_FL_RX], 1'b0);
      flags_q[`ESIC_FL_TX] <= esic_flag_next(flags_q[`ESIC_FL_TX], uart_tx_done_set,
        wr_flags, reg_wdata[`ESIC_FL_TX], 1'b0);
      flags_q[`ESIC_FL_T2OVF] <= esic_flag_next(flags_q[`ESIC_FL_T2OVF],
        timer2_overflow_set, wr_flags, reg_wdata[`ESIC_FL_T2OVF], 1'b0);
      flags_q[`ESIC_FL_T2EXT] <= esic_flag_next(flags_q[`ESIC_FL_T2EXT],
        timer2_external_set, wr_flags, reg_wdata[`ESIC_FL_T2EXT], 1'b0);
    end
  end

  // ----------------------------------------------------------------
  // Request to the core and in-service level tracking
  // ----------------------------------------------------------------
  // The presented request is re-evaluated every cycle until taken, so
  // a cancelled flag or a better newcomer replaces it before the ack.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      irq_req_q    <= 1'b0;
      irq_vector_q <= `ESIC_RST_BYTE;
      irq_src_q    <= `ESIC_SRC_EXT0;
      irq_lvl_q    <= `ESIC_LVL_NONE;
      active_q     <= 4'h0;
    end else begin
      if (vec_take)
        active_q <= active_q | esic_level_bit(irq_lvl_q);
      else if (cpu_reti)
        active_q <= active_q & ~reti_pop;
      if (vec_take || cpu_reti) begin
        irq_req_q <= 1'b0;
      end else begin
        irq_req_q    <= win_valid && (win_lvl < cur_lvl);
        irq_src_q    <= win_src;
        irq_lvl_q    <= win_lvl;
        irq_vector_q <= {2'b00, win_src, 3'b000} + `ESIC_VEC_BASE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port, data in the cycle after the strobe
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!nrst) begin
      reg_rdata <= `ESIC_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `ESIC_OFF_IRQ_EN:  reg_rdata <= irq_enable_q;
        `ESIC_OFF_PRIO_LO: reg_rdata <= prio_low_q;
        `ESIC_OFF_PRIO_HI: reg_rdata <= prio_high_q;
        `ESIC_OFF_EXT23:   reg_rdata <= ext23_ctrl_q;
        `ESIC_OFF_TIMER_CONTROL_REG:    reg_rdata <= timer_control_reg_q;
        `ESIC_OFF_FLAGS:   reg_rdata <= {4'h0, flags_q};
        `ESIC_OFF_STATUS:  reg_rdata <= {active_q, 1'b0, irq_src_q};
        default:           reg_rdata <= `ESIC_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `ESIC_RST_BYTE;
    end
  end

endmodule // esic_ctrl

`default_nettype wire

// >>> verif/esic_ctrl_props.sv
// Purpose: port level checks for the interrupt controller
// Assumes: sees only esic_ctrl ports, one clock domain
// Notes:   shadows enable bits from register writes
`timescale 1ns/1ps
`default_nettype none

module esic_ctrl_props (
  input wire       sys_clk,
  input wire       nrst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       cpu_ack,
  input wire       cpu_reti,
  input wire       irq_req_q,
  input wire [7:0] irq_vector_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Enable shadow: bit 8 global, 7:0 sources in polling order
  // ----------------------------------------------------------------
  // Delayed copy covers the one cycle the registered request lags
  reg [8:0] en_q;
  reg [8:0] en_p;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      en_q <= 9'h000;
      en_p <= 9'h000;
    end else begin
      en_p <= en_q;
      if (reg_wr && reg_addr == 4'h0) begin
        {en_q[8], en_q[5:0]} <= {reg_wdata[7], reg_wdata[5:0]};
      end
      if (reg_wr && reg_addr == 4'h3) begin
        {en_q[7], en_q[6]} <= {reg_wdata[6], reg_wdata[2]};
      end
    end
  end

  AST_GLOBAL_OFF: assert property (!en_q[8] && !en_p[8] |-> !irq_req_q)
    else $error("request while global enable clear");
  AST_EN_GATE: assert property (irq_req_q |-> en_p[irq_vector_q[5:3]])
    else $error("request from a disabled source");
  AST_VEC_FORM: assert property (irq_req_q |-> irq_vector_q[2:0] == 3'h3)
    else $error("vector off the eight byte grid");
  AST_ACK_DROP: assert property (cpu_ack && irq_req_q |=> !irq_req_q)
    else $error("request kept after acknowledge");
  AST_RETI_DROP: assert property (cpu_reti |=> !irq_req_q)
    else $error("request kept after return");
  AST_IE_READ: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == {en_q[8], 1'b0, en_q[5:0]})
    else $error("enable register read back wrong");
  AST_PL_TOP: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[7:6] == 2'h0)
    else $error("unused priority bits read nonzero");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");

  // Main scenarios reached
  cover property (cpu_ack && irq_req_q);
  cover property (cpu_reti);
  cover property (irq_req_q && irq_vector_q == 8'h3b);
endmodule // esic_ctrl_props

bind esic_ctrl esic_ctrl_props u_props (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .cpu_ack, .cpu_reti, .irq_req_q, .irq_vector_q);
`default_nettype wire

// >>> verif/esic_cpu_model.sv
// Purpose: core side that takes vectors and returns from routines
// Assumes: acknowledge only while a request is presented
// Notes:   return is commanded by the bench, never by itself
`timescale 1ns/1ps
`default_nettype none

module esic_cpu_model #(
  parameter ACK_WAIT = 2
) (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire       irq_req_q,
  input  wire [7:0] irq_vector_q,
  input  wire       auto_ack,
  input  wire       reti_go,
  output reg        cpu_ack,
  output reg        cpu_reti,
  output reg  [7:0] last_vec,
  output reg  [7:0] acks
);
  reg [3:0] wait_q;

  // Pulses last one cycle; a slow wait mimics a busy instruction.
  // The vector is taken at the edge where the controller sees the ack,
  // because the winner may still change while the ack is on its way.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      cpu_ack  <= 1'b0;
      cpu_reti <= 1'b0;
      wait_q   <= 4'h0;
      acks     <= 8'h00;
      last_vec <= 8'h00;
    end else begin
      cpu_reti <= reti_go;
      if (cpu_ack) begin
        cpu_ack <= 1'b0;
        wait_q  <= 4'h0;
        if (irq_req_q) begin
          last_vec <= irq_vector_q;
          acks     <= acks + 8'h01;
        end
      end else if (auto_ack && irq_req_q && !reti_go) begin
        if (wait_q == ACK_WAIT) begin
          cpu_ack <= 1'b1;
          wait_q  <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule // esic_cpu_model
`default_nettype wire

// >>> verif/tb.sv
// Purpose: self checking bench for the interrupt controller
// Assumes: 125 MHz clock, synchronous active low reset
// Notes:   external pins released by the bench after service
`timescale 1ns/1ps
`default_nettype none

module tb;
  reg        sys_clk = 1'b0;
  reg        nrst = 1'b0;
  reg  [3:0] reg_addr = 4'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg  [3:0] pin_n = 4'hf;
  reg  [5:0] set_p = 6'h00;
  reg        auto_ack = 1'b0;
  reg        reti_go = 1'b0;
  wire [7:0] reg_rdata;
  wire       cpu_ack;
  wire       cpu_reti;
  wire       irq_req_q;
  wire [7:0] irq_vector_q;
  wire [7:0] last_vec;
  wire [7:0] acks;
  integer    miscompares = 0;
  integer    tests_run = 0;
  integer    cycles = 0;

  esic_ctrl DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq0_pin(pin_n[0]),
    .ext_irq1_pin(pin_n[1]), .ext_irq2_pin(pin_n[2]), .ext_irq3_pin(pin_n[3]),
    .timer0_rollover(set_p[0]), .timer1_rollover(set_p[1]), .timer2_overflow_set(set_p[2]),
    .timer2_external_set(set_p[3]), .uart_rx_done_set(set_p[4]), .uart_tx_done_set(set_p[5]),
    .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q));

  esic_cpu_model u_cpu (.sys_clk(sys_clk), .nrst(nrst), .irq_req_q(irq_req_q),
    .irq_vector_q(irq_vector_q), .auto_ack(auto_ack), .reti_go(reti_go), .cpu_ack(cpu_ack),
    .cpu_reti(cpu_reti), .last_vec(last_vec), .acks(acks));

  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask

  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end

  task check(input [8*6-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
    end
  endtask

  // Gap cycle after each strobe so no strobe is driven twice in a step
  task wr(input [3:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task rd(input [3:0] a, input [7:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check("rdata", exp, reg_rdata);
      @(posedge sys_clk);
    end
  endtask

  task wait_ack(input [7:0] exp);
    integer n;
    integer a0;
    begin
      a0 = acks;
      n = 0;
      while (acks == a0 && n < 200) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      check("vector", exp, last_vec);
      check("acks", a0[7:0] + 8'h01, acks);
    end
  endtask

  task ret_pulse;
    begin
      reti_go <= 1'b1;
      @(posedge sys_clk);
      reti_go <= 1'b0;
      tick(3);
    end
  endtask

  task chk_idle;
    begin
      tick(6);
      check("req", 8'h00, {7'h00, irq_req_q});
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    integer i;
    begin
      for (i = 0; i < 7; i = i + 1) rd(i[3:0], 8'h00);
      wr(4'h0, 8'hff);
      wr(4'h1, 8'hff);
      wr(4'h2, 8'hff);
      wr(4'h3, 8'hcc);
      wr(4'hf, 8'hff);
      rd(4'h0, 8'hbf);
      rd(4'h1, 8'h3f);
      rd(4'h2, 8'hff);
      rd(4'h3, 8'hcc);
      rd(4'hf, 8'h00);
      for (i = 0; i < 4; i = i + 1) wr(i[3:0], 8'h00);
    end
  endtask

  task t_global;
    begin
      wr(4'h0, 8'h02);
      wr(4'h4, 8'h20);
      chk_idle;
      wr(4'h0, 8'h80);
      chk_idle;
      auto_ack <= 1'b1;
      wr(4'h0, 8'h82);
      wait_ack(8'h0b);
      ret_pulse;
      auto_ack <= 1'b0;
      wr(4'h0, 8'h02);
      wr(4'h4, 8'h20);
      wr(4'h4, 8'h00);
      wr(4'h0, 8'h82);
      chk_idle;
      wr(4'h0, 8'h00);
    end
  endtask

  // Level 0 ext3, level 1 timer1, the rest level 3 in polling order
  task t_order;
    integer i;
    reg [63:0] ord;
    begin
      ord = 64'h3b1b030b13232b33;
      wr(4'h3, 8'hd5);
      wr(4'h2, 8'h88);
      wr(4'h0, 8'hbf);
      pin_n <= 4'h0;
      set_p <= 6'h3f;
      @(posedge sys_clk);
      set_p <= 6'h00;
      tick(6);
      rd(4'h3, 8'hf7);
      auto_ack <= 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        wait_ack(ord[63-8*i -: 8]);
        chk_idle;
        case (ord[63-8*i -: 8])
          8'h03: pin_n[0] <= 1'b1;
          8'h13: pin_n[1] <= 1'b1;
          8'h23: begin
            rd(4'h5, 8'h0f);
            wr(4'h5, 8'h0c);
          end
          8'h2b: begin
            rd(4'h5, 8'h0c);
            wr(4'h5, 8'h00);
          end
          default: tick(1);
        endcase
        tick(6);
        ret_pulse;
      end
      rd(4'h3, 8'hd5);
      rd(4'h4, 8'h00);
      pin_n <= 4'hf;
      auto_ack <= 1'b0;
      for (i = 0; i < 4; i = i + 1) wr(i[3:0], 8'h00);
    end
  endtask

  // Ext0 latched on a falling edge, ext2 following a low level
  task t_edge;
    begin
      wr(4'h4, 8'h05);
      wr(4'h0, 8'h81);
      auto_ack <= 1'b1;
      pin_n <= 4'he;
      wait_ack(8'h03);
      rd(4'h4, 8'h05);
      ret_pulse;
      chk_idle;
      wr(4'h3, 8'h04);
      pin_n <= 4'ha;
      wait_ack(8'h33);
      rd(4'h3, 8'h06);
      pin_n <= 4'hf;
      tick(4);
      ret_pulse;
      chk_idle;
      auto_ack <= 1'b0;
      wr(4'h4, 8'h00);
      wr(4'h3, 8'h00);
      wr(4'h0, 8'h00);
    end
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_regs;
    t_global;
    t_order;
    t_edge;
    conclude;
  end
endmodule // tb
`default_nettype wire
